// *** bfs_defs.svh ***
/*
 Shared constants of the boost fault supervisor: timing figures and counts.
 Assumes a 10 MHz core clock; counts derive from the period below.
*/
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH
`define BFS_CLK_PERIOD_NS 100
`define BFS_START_WIN_MS 5
`define BFS_RETRY_OFF_MS 55
`define BFS_UV_HOLD_MS 55
`define BFS_MS_CYCLES (1000000 / `BFS_CLK_PERIOD_NS)
`define BFS_START_WIN_CYC (`BFS_START_WIN_MS * `BFS_MS_CYCLES)
`define BFS_RETRY_OFF_CYC (`BFS_RETRY_OFF_MS * `BFS_MS_CYCLES)
`define BFS_UV_HOLD_CYC (`BFS_UV_HOLD_MS * `BFS_MS_CYCLES)
`define BFS_MAX_ATTEMPTS 3
`define BFS_CNT_W 20
`define BFS_TRY_W 2
`define BFS_TRY_ZERO 2'h0
`define BFS_TRY_ONE 2'h1
`define BFS_CNT_ZERO 20'h00000
`define BFS_CNT_ONE 20'h00001
`endif

// *** bfs_pkg.sv ***
/*
 Types of the boost fault supervisor.
 Assumes bfs_defs.svh is included by every user.
*/
`include "bfs_defs.svh"
package bfs_pkg;
   // Supervisor states
   typedef enum logic [2:0] {
      BFS_OFF = 3'h0,
      BFS_START = 3'h1,
      BFS_RETRY = 3'h2,
      BFS_SOFT = 3'h3,
      BFS_RUN = 3'h4,
      BFS_LATCH = 3'h5
   } bfs_state_t;

   // Comparator results from the analog stage
   typedef struct packed {
      logic boost_output_sense_ok;
      logic feedback_sense_pg;
      logic feedback_sense_short;
      logic overvoltage_guard_trip;
      logic overvoltage_guard_clear;
   } bfs_sense_t;

   // Controls toward the power stage
   typedef struct packed {
      logic isolation_gate_drive_sink;
      logic switch_enable;
      logic soft_start_discharge;
      logic full_current_limit;
      logic switch_rate_high;
      logic stress_feedback_switch;
   } bfs_ctrl_t;
endpackage : bfs_pkg

// *** bfs_timer.sv ***
/*
 Down-counting timer used for the start window, retry off time and
 undervoltage hold. Assumes the caller loads it and watches expiry.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bfs_defs.svh"
module bfs_timer (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [`BFS_CNT_W-1:0] load_val_i,
   input wire logic stop_i,
   output logic expired_o
);
   logic [`BFS_CNT_W-1:0] cnt_ff;
   logic run_ff;

   // Count down to one, then flag expiry once
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt_ff <= `BFS_CNT_ZERO;
         run_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         if (load_i)
         begin
            cnt_ff <= load_val_i;
            run_ff <= 1'b1;
         end
         else if (stop_i || (run_ff && cnt_ff == `BFS_CNT_ONE))
            run_ff <= 1'b0;
         else if (run_ff)
            cnt_ff <= cnt_ff - `BFS_CNT_ONE;
      end
   end

   // Pulse in the last counted cycle; kept free of load and stop, which the
   // caller derives from this flag, so no combinational loop can form
   assign expired_o = run_ff && (cnt_ff == `BFS_CNT_ONE);
endmodule : bfs_timer
`default_nettype wire

// *** bfs_supervisor.sv ***
/*
 Control and fault supervision of a boost converter: start-up with retry,
 short and undervoltage latch, overvoltage blanking, soft-start discharge,
 rate and stress selection. Assumes comparator inputs are synchronous to
 clk_i and that the caller flags floating select pins on their float inputs.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bfs_defs.svh"
// Overview of operation
// - With supply good and enable high, sink gate drive and watch output.
// - Output below 46% of input after 5 ms: gate off 55 ms, retry.
// - Three failed attempts latch gate off until supply or enable cycles.
// - After power good, feedback below 30% reference latches off.
// - Feedback near 97% nominal gives power good and full current limit.
// - Output under power good over 55 ms in operation shuts device off.
// - Overvoltage stops switching at once; resumes below hysteresis level.
// - Enable low discharges the soft-start capacitor.
// - Rate select low gives 640 kHz, high gives 1.2 MHz.
// - Floating rate select reads high, choosing the faster rate.
// - Stress select high closes stress feedback switch to ground.
// - Floating stress select reads low, stress mode off.
module bfs_supervisor (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic input_lockout_ok_i,
   input wire logic enable_i,
   input wire logic switch_rate_select_i,
   input wire logic switch_rate_select_float_i,
   input wire logic stress_test_select_i,
   input wire logic stress_test_select_float_i,
   input wire bfs_pkg::bfs_sense_t sense_i,
   output bfs_pkg::bfs_ctrl_t ctrl_o,
   output logic power_good_o,
   output logic fault_latched_o,
   output logic [`BFS_TRY_W-1:0] attempts_o
);
   bfs_pkg::bfs_state_t state_ff;
   bfs_pkg::bfs_state_t nxt_state;
   logic [`BFS_TRY_W-1:0] tries_ff;
   logic ovp_block_ff;
   logic active;
   logic tmr_load;
   logic tmr_stop;
   logic tmr_exp;
   logic [`BFS_CNT_W-1:0] tmr_val;
   logic rate_high;
   logic stress_on;
   logic [`BFS_TRY_W-1:0] max_tries;

   assign max_tries = `BFS_TRY_W'(`BFS_MAX_ATTEMPTS);

   // Supply good and enable form the operating condition
   assign active = input_lockout_ok_i && enable_i;

   // Pull resistors: a floating pin resolves to its default level
   assign rate_high = switch_rate_select_float_i ? 1'b1 : switch_rate_select_i;
   assign stress_on = stress_test_select_float_i ? 1'b0 : stress_test_select_i;

   // One timer serves all phases since only one phase runs at a time
   bfs_timer u_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .load_i(tmr_load),
      .load_val_i(tmr_val),
      .stop_i(tmr_stop),
      .expired_o(tmr_exp)
   );

   // Next state and timer loads
   always_comb
   begin
      nxt_state = state_ff;
      tmr_load = 1'b0;
      tmr_stop = 1'b0;
      tmr_val = `BFS_CNT_W'(`BFS_START_WIN_CYC);
      if (!active)
      begin
         nxt_state = bfs_pkg::BFS_OFF;
         tmr_stop = 1'b1;
      end
      else
      begin
         unique case (state_ff)
            bfs_pkg::BFS_OFF:
            begin
               nxt_state = bfs_pkg::BFS_START;
               tmr_load = 1'b1;
            end
            bfs_pkg::BFS_START:
            begin
               if (sense_i.boost_output_sense_ok)
               begin
                  nxt_state = bfs_pkg::BFS_SOFT;
                  tmr_stop = 1'b1;
               end
               else if (tmr_exp)
               begin
                  // Third failure latches instead of retrying
                  if (tries_ff + `BFS_TRY_ONE >= max_tries)
                     nxt_state = bfs_pkg::BFS_LATCH;
                  else
                  begin
                     nxt_state = bfs_pkg::BFS_RETRY;
                     tmr_load = 1'b1;
                     tmr_val = `BFS_CNT_W'(`BFS_RETRY_OFF_CYC);
                  end
               end
            end
            bfs_pkg::BFS_RETRY:
            begin
               if (tmr_exp)
               begin
                  nxt_state = bfs_pkg::BFS_START;
                  tmr_load = 1'b1;
               end
            end
            bfs_pkg::BFS_SOFT:
            begin
               if (sense_i.feedback_sense_pg)
                  nxt_state = bfs_pkg::BFS_RUN;
            end
            bfs_pkg::BFS_RUN:
            begin
               if (sense_i.feedback_sense_short)
               begin
                  nxt_state = bfs_pkg::BFS_LATCH;
                  tmr_stop = 1'b1;
               end
               else if (tmr_exp)
                  nxt_state = bfs_pkg::BFS_LATCH;
               else if (!sense_i.feedback_sense_pg)
               begin
                  // Start undervoltage hold on the first low cycle only
                  if (power_good_o)
                  begin
                     tmr_load = 1'b1;
                     tmr_val = `BFS_CNT_W'(`BFS_UV_HOLD_CYC);
                  end
               end
               else
                  tmr_stop = 1'b1;
            end
            bfs_pkg::BFS_LATCH:
               nxt_state = bfs_pkg::BFS_LATCH;
            default:
               nxt_state = bfs_pkg::BFS_OFF;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         state_ff <= bfs_pkg::BFS_OFF;
      else if (ce_i)
         state_ff <= nxt_state;
   end

   // Failed-attempt counter, cleared when supply or enable drop
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         tries_ff <= `BFS_TRY_ZERO;
      else if (ce_i)
      begin
         if (!active)
            tries_ff <= `BFS_TRY_ZERO;
         else if (state_ff == bfs_pkg::BFS_START && tmr_exp &&
                  !sense_i.boost_output_sense_ok && tries_ff < max_tries)
            tries_ff <= tries_ff + `BFS_TRY_ONE;
      end
   end

   // Overvoltage blanking with hysteresis; trip wins over clear
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ovp_block_ff <= 1'b0;
      else if (ce_i)
      begin
         if (sense_i.overvoltage_guard_trip)
            ovp_block_ff <= 1'b1;
         else if (sense_i.overvoltage_guard_clear)
            ovp_block_ff <= 1'b0;
      end
   end

   // Power good flag tracks the run state with feedback in range
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         power_good_o <= 1'b0;
      else if (ce_i)
         power_good_o <= (nxt_state == bfs_pkg::BFS_RUN) && sense_i.feedback_sense_pg;
   end

   // Registered controls toward the power stage
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         ctrl_o <= '0;
      else if (ce_i)
      begin
         ctrl_o.isolation_gate_drive_sink <= (nxt_state == bfs_pkg::BFS_START) ||
            (nxt_state == bfs_pkg::BFS_SOFT) || (nxt_state == bfs_pkg::BFS_RUN);
         // Overvoltage trip is seen combinationally so blanking is immediate
         ctrl_o.switch_enable <= ((nxt_state == bfs_pkg::BFS_START) ||
            (nxt_state == bfs_pkg::BFS_SOFT) || (nxt_state == bfs_pkg::BFS_RUN)) &&
            !sense_i.overvoltage_guard_trip &&
            !(ovp_block_ff && !sense_i.overvoltage_guard_clear);
         ctrl_o.soft_start_discharge <= !enable_i;
         ctrl_o.full_current_limit <= (nxt_state == bfs_pkg::BFS_RUN);
         ctrl_o.switch_rate_high <= rate_high;
         ctrl_o.stress_feedback_switch <= stress_on;
      end
   end

   // Status
   assign fault_latched_o = (state_ff == bfs_pkg::BFS_LATCH);
   assign attempts_o = tries_ff;
endmodule : bfs_supervisor
`default_nettype wire

// *** bfs_supervisor_assertions.sv ***
/* Port checker of the boost fault supervisor, bound into it.
   Assumes one clock domain and an async active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module bfs_checker (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic input_lockout_ok_i,
   input wire logic enable_i,
   input wire logic switch_rate_select_i,
   input wire logic switch_rate_select_float_i,
   input wire logic stress_test_select_i,
   input wire logic stress_test_select_float_i,
   input wire bfs_pkg::bfs_sense_t sense_i,
   input wire bfs_pkg::bfs_ctrl_t ctrl_o,
   input wire logic power_good_o,
   input wire logic fault_latched_o,
   input wire logic [1:0] attempts_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // Supply good and enable, only while the core is running
   wire logic act = ce_i & input_lockout_ok_i & enable_i;
   // Idle with no fault: the next edge starts an attempt
   sequence s_idle;
      act && !ctrl_o.isolation_gate_drive_sink && !fault_latched_o && attempts_o == 2'h0;
   endsequence
   // Short seen while in normal operation
   sequence s_short;
      act && power_good_o && sense_i.feedback_sense_short;
   endsequence
   gate_off_a: assert property (ce_i && !act |=> !ctrl_o.isolation_gate_drive_sink
      && !fault_latched_o && attempts_o == 2'h0) else $error("gate or fault left set");
   start_sink_a: assert property (s_idle |=> ctrl_o.isolation_gate_drive_sink)
      else $error("start attempt not begun");
   rate_pick_a: assert property (act |=> ctrl_o.switch_rate_high ==
      ($past(switch_rate_select_i) | $past(switch_rate_select_float_i)))
      else $error("rate wrong");
   stress_pick_a: assert property (act |=> ctrl_o.stress_feedback_switch ==
      ($past(stress_test_select_i) & !$past(stress_test_select_float_i)))
      else $error("stress wrong");
   discharge_a: assert property (ce_i |=> ctrl_o.soft_start_discharge == !$past(enable_i))
      else $error("discharge wrong");
   ovp_block_a: assert property (ce_i && sense_i.overvoltage_guard_trip
      |=> !ctrl_o.switch_enable) else $error("switching during overvoltage");
   short_latch_a: assert property (s_short |=> fault_latched_o
      && !ctrl_o.isolation_gate_drive_sink) else $error("short not latched");
   pg_limit_a: assert property (power_good_o |-> ctrl_o.full_current_limit)
      else $error("limit not full");
   latch_hold_a: assert property (act && fault_latched_o |=> fault_latched_o)
      else $error("latch left early");
endmodule : bfs_checker
bind bfs_supervisor bfs_checker chk (.clk_i, .sys_rst_i, .ce_i, .input_lockout_ok_i, .enable_i,
   .switch_rate_select_i, .switch_rate_select_float_i, .stress_test_select_i,
   .stress_test_select_float_i, .sense_i, .ctrl_o, .power_good_o, .fault_latched_o, .attempts_o);
`default_nettype wire

// *** bfs_stage_model.sv ***
/* Behavioural power stage: isolation switch, comparators, divider.
   Assumes the supervisor controls change on clk_i. */
`timescale 1ns/100ps
`default_nettype none
module bfs_stage_model (
   input wire logic clk_i,
   input wire bfs_pkg::bfs_ctrl_t ctrl_i,
   input wire logic short_i,
   input wire logic over_i,
   output bfs_pkg::bfs_sense_t sense_o
);
   logic out_ok_ff;
   logic fb_pg_ff;
   // Output rises a cycle after the switch closes; a short holds it down
   always_ff @(posedge clk_i)
   begin
      out_ok_ff <= ctrl_i.isolation_gate_drive_sink & ~short_i;
      fb_pg_ff <= out_ok_ff;
   end
   // Hysteresis is zero here, so clear is just the complement of trip
   assign sense_o = {out_ok_ff, fb_pg_ff, short_i, over_i, ~over_i};
endmodule : bfs_stage_model
`default_nettype wire

// *** tb_bfs_supervisor.sv ***
/* Self-checking bench of the boost fault supervisor.
   Assumes the design counts at the 10 MHz figures of its header. */
`timescale 1ns/100ps
`default_nettype none
module tb_bfs_supervisor;
   logic clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic en = 1'h1;
   logic ce = 1'h1;
   logic lko = 1'h1; // Supply above lockout
   logic [3:0] sel = 4'h0; // Rate, rate float, stress, stress float
   logic shrt = 1'h0;
   logic ovr = 1'h0;
   bfs_pkg::bfs_sense_t sense;
   bfs_pkg::bfs_ctrl_t ctrl;
   logic pg;
   logic fl;
   logic [1:0] att;
   int n_errors = 0;
   int compares = 0;
   bfs_supervisor dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
      .input_lockout_ok_i(lko), .enable_i(en), .switch_rate_select_i(sel[3]),
      .switch_rate_select_float_i(sel[2]), .stress_test_select_i(sel[1]),
      .stress_test_select_float_i(sel[0]), .sense_i(sense), .ctrl_o(ctrl),
      .power_good_o(pg), .fault_latched_o(fl), .attempts_o(att));
   bfs_stage_model stage (.clk_i(clk_i), .ctrl_i(ctrl), .short_i(shrt), .over_i(ovr),
      .sense_o(sense));
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   // Inputs move only on falling edges, away from sampling
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk_bit
   task automatic chk_cnt(input logic [1:0] got, input logic [1:0] exp, input string msg);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk_cnt
   task automatic t_reset;
      cyc(6);
      chk_bit(ctrl === 6'h00, 1'h1, "ctrl not off in reset");
      sys_rst_i = 1'h0;
      cyc(1);
      chk_bit(ctrl.isolation_gate_drive_sink, 1'h1, "no sink after start");
      $display("test reset done");
   endtask : t_reset
   task automatic t_run;
      for (int i = 0; i < 20 && pg !== 1'h1; i++)
         cyc(1);
      chk_bit(pg, 1'h1, "no power good");
      chk_bit(ctrl.full_current_limit, 1'h1, "limit not full");
      $display("test run done");
   endtask : t_run
   // Every pin combination, floating included
   task automatic t_select;
      for (int i = 0; i < 16; i++)
      begin
         sel = i[3:0];
         cyc(2);
         chk_bit(ctrl.switch_rate_high, sel[3] | sel[2], "rate");
         chk_bit(ctrl.stress_feedback_switch, sel[1] & ~sel[0], "stress");
      end
      $display("test select done");
   endtask : t_select
   task automatic t_ovp;
      ovr = 1'h1;
      cyc(2);
      chk_bit(ctrl.switch_enable, 1'h0, "switching in overvoltage");
      ovr = 1'h0;
      cyc(2);
      chk_bit(ctrl.switch_enable, 1'h1, "no resume");
      $display("test ovp done");
   endtask : t_ovp
   // Clock enable low freezes everything; supply drops below lockout in the same step
   task automatic t_freeze;
      ce = 1'h0;
      lko = 1'h0;
      cyc(3);
      chk_bit(ctrl.isolation_gate_drive_sink, 1'h1, "state moved while frozen");
      chk_bit(pg, 1'h1, "power good lost while frozen");
      ce = 1'h1;
      cyc(2);
      chk_bit(ctrl.isolation_gate_drive_sink, 1'h0, "gate on in lockout");
      chk_bit(pg, 1'h0, "power good kept in lockout");
      chk_cnt(att, 2'h0, "count kept in lockout");
      lko = 1'h1;
      $display("test freeze done");
   endtask : t_freeze
   task automatic t_short;
      shrt = 1'h1;
      cyc(2);
      chk_bit(fl, 1'h1, "short not latched");
      chk_bit(ctrl.isolation_gate_drive_sink, 1'h0, "gate on in latch");
      en = 1'h0;
      cyc(2);
      chk_bit(fl, 1'h0, "latch kept");
      chk_bit(ctrl.soft_start_discharge, 1'h1, "no discharge");
      $display("test short done");
   endtask : t_short
   // Short kept: the 5 ms window of 50000 cycles runs out
   task automatic t_fail;
      en = 1'h1;
      cyc(49990);
      chk_bit(ctrl.isolation_gate_drive_sink, 1'h1, "window cut short");
      cyc(20);
      chk_bit(ctrl.isolation_gate_drive_sink, 1'h0, "no off time");
      chk_cnt(att, 2'h1, "attempt count");
      chk_bit(fl, 1'h0, "latched on first failure");
      en = 1'h0;
      cyc(2);
      chk_cnt(att, 2'h0, "count kept");
      $display("test fail done");
   endtask : t_fail
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   initial
   begin
      t_reset();
      t_run();
      t_select();
      t_ovp();
      t_freeze();
      t_run();
      t_short();
      t_fail();
      close_out();
   end
   // Tests need about 5.0 ms; cut a hang at 8 ms
   initial
   begin
      #8000000;
      n_errors++;
      close_out();
   end
endmodule : tb_bfs_supervisor
`default_nettype wire
